// [logic/steif_sync.v]
// Two-flop synchroniser bank with edge detection for pin inputs.
`timescale 1ns/1ps
`default_nettype none

module steif_sync #(
  parameter W = 1
) (
  // Clock and reset.
  input  wire         ref_clk,
  input  wire         rst,
  // Asynchronous pin levels.
  input  wire [W-1:0] pin_in,
  // Synchronised level and one-cycle edge pulses.
  output wire [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  genvar i;

  // Each bit gets two capture flops plus a history flop; only the second
  // and third stages feed the edge detectors, never the first.
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      reg hist_reg;
      always @(posedge ref_clk) begin
        if (rst) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
          hist_reg <= 1'b0;
        end else begin
          meta_reg <= pin_in[i];
          sync_reg <= meta_reg;
          hist_reg <= sync_reg;
        end
      end
      assign level[i] = sync_reg;
      assign rise[i]  = sync_reg & ~hist_reg;
      assign fall[i]  = ~sync_reg & hist_reg;
    end
  endgenerate

endmodule // steif_sync

`default_nettype wire

// [logic/steif_top.v]
// Digital side of the shock, transient and converter link between two sections.
//
// Summary of operation
// RL1 - Converter port moves data only while the select input is low.
// RL2 - Controller shifts the configuration word in on the serial input.
// RL3 - Device shifts the conversion result out on the serial output.
// RL4 - All converter serial movement follows the shift clock input.
// RL5 - Conversion is paced by a separate conversion clock input.
// RL6 - Controller pulses shock advance and watches the MSB to learn the count.
// RL7 - Outside battery mode the MSB output follows the counter MSB.
// RL8 - Two transient flags are held and shown to the controller.
// RL9 - The clear input resets both transient flags together.
// RL10 - A transient raises the transient interrupt line.
// RL11 - A shock raises the separate shock interrupt line.
// RL12 - The self-test input clocks both transient flags into the detected state.
// RL13 - Battery mode is on while backup voltage exceeds the main input.
// RL14 - In battery mode only the shock counter stays active.
// RL15 - The counter steps once per shock above the acceleration threshold.
// RL16 - Shocks are counted while running from battery.
// RL17 - The counter saturates at 127 and ignores further shocks.
// RL18 - Under main power the counter idles and shocks go to the interrupt.
// RL19 - Reset returns the supervision logic to its initial state.
// RL20 - Flags stay set until cleared; interrupt stays high while either is set.
// RL21 - The shock counter is seven bits wide.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "steif_regs.vh"

module steif_top (
  // Clock and synchronous reset.
  input  wire                       ref_clk,
  input  wire                       rst,
  // Register port.
  input  wire [`STEIF_ADDR_W-1:0]   reg_addr,
  input  wire [`STEIF_DATA_W-1:0]   reg_wdata,
  input  wire                       reg_wr,
  input  wire                       reg_rd,
  output reg  [`STEIF_DATA_W-1:0]   reg_rdata,
  // Converter serial port from the controller.
  input  wire                       conv_select_n,
  input  wire                       conv_sdi,
  input  wire                       conv_sclk,
  input  wire                       conv_aclk,
  output reg                        conv_sdo,
  output reg                        conv_sdo_oe,
  // Shock counter lines.
  input  wire                       shock_advance,
  output reg                        shock_count_msb,
  output reg                        shock_irq,
  // Transient lines.
  input  wire                       transient_flag_clear,
  input  wire                       transient_self_test,
  output reg                        transient_flag_a,
  output reg                        transient_flag_b,
  output wire                       transient_irq,
  // Analog comparator results.
  input  wire                       shock_detect,
  input  wire                       transient_hit_a,
  input  wire                       transient_hit_b,
  input  wire                       batt_above_main
);

  // Converter sequencer states.
  localparam ST_IDLE  = 3'b001;
  localparam ST_CONV  = 3'b010;
  localparam ST_READY = 3'b100;

  wire [`STEIF_NSYNC-1:0] pin_vec;
  wire [`STEIF_NSYNC-1:0] lvl;
  wire [`STEIF_NSYNC-1:0] rise;
  wire [`STEIF_NSYNC-1:0] fall;

  reg                       batt_meta_reg;
  reg                       batt_mode_reg;
  reg [`STEIF_CNT_W-1:0]    shock_cnt_reg;
  reg [`STEIF_CONV_W-1:0]   result_reg;
  reg [`STEIF_CONV_W-1:0]   config_reg;
  reg [`STEIF_LEN_W-1:0]    conv_len_reg;
  reg [`STEIF_CONV_W-1:0]   in_shift_reg;
  reg [`STEIF_CONV_W-1:0]   out_shift_reg;
  reg [`STEIF_CONV_W-1:0]   held_result_reg;
  reg [`STEIF_BITCNT_W-1:0] bit_cnt_reg;
  reg [`STEIF_LEN_W-1:0]    aclk_cnt_reg;
  reg [2:0]                 state_reg;
  reg [2:0]                 state_next;
  reg                       conv_done_reg;

  wire sel_active;
  wire start_conv;
  wire conv_end;

  // All pins come from the controller or the analog section, so every one
  // is synchronised before it is looked at. Select enters inverted, so its
  // idle level matches the flops' reset value and no false frame follows reset.
  assign pin_vec[`STEIF_IX_SEL_N] = ~conv_select_n;
  assign pin_vec[`STEIF_IX_SDI]   = conv_sdi;
  assign pin_vec[`STEIF_IX_SCLK]  = conv_sclk;
  assign pin_vec[`STEIF_IX_ACLK]  = conv_aclk;
  assign pin_vec[`STEIF_IX_ADV]   = shock_advance;
  assign pin_vec[`STEIF_IX_CLR]   = transient_flag_clear;
  assign pin_vec[`STEIF_IX_TEST]  = transient_self_test;
  assign pin_vec[`STEIF_IX_SHOCK] = shock_detect;
  assign pin_vec[`STEIF_IX_HIT_A] = transient_hit_a;
  assign pin_vec[`STEIF_IX_HIT_B] = transient_hit_b;

  steif_sync #(
    .W (`STEIF_NSYNC)
  ) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .pin_in  (pin_vec),
    .level   (lvl),
    .rise    (rise),
    .fall    (fall)
  );

  // Battery mode follows the supply comparator after two flops; reset puts
  // the supervision logic back on main power.
  always @(posedge ref_clk) begin
    if (rst) begin
      batt_meta_reg <= 1'b0; // RL19
      batt_mode_reg <= 1'b0; // RL19
    end else begin
      batt_meta_reg <= batt_above_main;
      batt_mode_reg <= batt_meta_reg; // RL13
    end
  end

  // The only active path in battery mode is shock counting; the advance
  // line is served under main power when the controller is awake.
  always @(posedge ref_clk) begin
    if (rst) begin
      shock_cnt_reg <= `STEIF_CNT_ZERO;
    end else if (batt_mode_reg) begin
      if (rise[`STEIF_IX_SHOCK] && shock_cnt_reg != `STEIF_CNT_MAX) begin // RL17
        shock_cnt_reg <= shock_cnt_reg + `STEIF_CNT_ONE; // RL15 RL16 RL21
      end
    end else if (rise[`STEIF_IX_ADV]) begin
      // Advance wraps so the controller sees the MSB toggle after stepping.
      shock_cnt_reg <= shock_cnt_reg + `STEIF_CNT_ONE; // RL6
    end
  end

  // Counter MSB and shock interrupt are only meaningful on main power.
  always @(posedge ref_clk) begin
    if (rst) begin
      shock_count_msb <= 1'b0;
      shock_irq       <= 1'b0;
    end else begin
      shock_count_msb <= ~batt_mode_reg & shock_cnt_reg[`STEIF_CNT_W-1]; // RL7 RL14
      shock_irq       <= ~batt_mode_reg & lvl[`STEIF_IX_SHOCK]; // RL11 RL18
    end
  end

  // Transient flags: a hit or a self-test edge sets, the clear input resets
  // both. A set in the same cycle as a clear wins so no event is lost.
  always @(posedge ref_clk) begin
    if (rst) begin
      transient_flag_a <= 1'b0;
      transient_flag_b <= 1'b0;
    end else if (!batt_mode_reg) begin
      if (lvl[`STEIF_IX_HIT_A] || rise[`STEIF_IX_TEST]) begin // RL12
        transient_flag_a <= 1'b1; // RL8
      end else if (lvl[`STEIF_IX_CLR]) begin
        transient_flag_a <= 1'b0; // RL9
      end
      if (lvl[`STEIF_IX_HIT_B] || rise[`STEIF_IX_TEST]) begin // RL12
        transient_flag_b <= 1'b1; // RL8
      end else if (lvl[`STEIF_IX_CLR]) begin
        transient_flag_b <= 1'b0; // RL9
      end
    end
  end

  // Interrupt holds as long as either flag holds.
  assign transient_irq = transient_flag_a | transient_flag_b; // RL10 RL20

  // Converter port is live only with select low and main power present.
  assign sel_active = lvl[`STEIF_IX_SEL_N] & ~batt_mode_reg; // RL1 RL14

  // A complete configuration word followed by deselect starts a conversion.
  assign start_conv = fall[`STEIF_IX_SEL_N] && bit_cnt_reg >= `STEIF_BITCNT_FULL;

  // The conversion ends after the programmed number of conversion clocks.
  assign conv_end = rise[`STEIF_IX_ACLK] && aclk_cnt_reg >= conv_len_reg - `STEIF_LEN_ONE;

  // Serial shifting: sample input on shift-clock rise, present the next
  // output bit on shift-clock fall, most significant bit first.
  always @(posedge ref_clk) begin
    if (rst) begin
      in_shift_reg  <= `STEIF_RESULT_RESET;
      out_shift_reg <= `STEIF_RESULT_RESET;
      bit_cnt_reg   <= `STEIF_BITCNT_ZERO;
      config_reg    <= `STEIF_RESULT_RESET;
    end else begin
      if (rise[`STEIF_IX_SEL_N]) begin
        out_shift_reg <= held_result_reg;
        bit_cnt_reg   <= `STEIF_BITCNT_ZERO;
      end else if (sel_active) begin
        if (rise[`STEIF_IX_SCLK]) begin
          in_shift_reg <= {in_shift_reg[`STEIF_CONV_W-2:0], lvl[`STEIF_IX_SDI]}; // RL2 RL4
          if (bit_cnt_reg != `STEIF_BITCNT_FULL) begin
            bit_cnt_reg <= bit_cnt_reg + `STEIF_BITCNT_ONE;
          end
        end
        if (fall[`STEIF_IX_SCLK]) begin
          out_shift_reg <= {out_shift_reg[`STEIF_CONV_W-2:0], 1'b0}; // RL3 RL4
        end
      end
      if (start_conv) begin
        config_reg <= in_shift_reg;
      end
    end
  end

  // Output pin is driven only while selected; it is a flop so the bit on
  // the pin never glitches between shift-clock edges.
  always @(posedge ref_clk) begin
    if (rst) begin
      conv_sdo    <= 1'b0;
      conv_sdo_oe <= 1'b0;
    end else begin
      conv_sdo    <= sel_active & out_shift_reg[`STEIF_CONV_W-1]; // RL3
      conv_sdo_oe <= sel_active; // RL1
    end
  end

  // Conversion sequencer, started by a full-word deselect and paced by the conversion clock edges.
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (start_conv) begin
          state_next = ST_CONV;
        end
      end
      ST_CONV: begin
        if (batt_mode_reg) begin
          state_next = ST_IDLE;
        end else if (conv_end) begin
          state_next = ST_READY; // RL5
        end
      end
      ST_READY: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state_reg       <= ST_IDLE;
      aclk_cnt_reg    <= {`STEIF_LEN_W{1'b0}};
      held_result_reg <= `STEIF_RESULT_RESET;
      conv_done_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE) begin
        aclk_cnt_reg <= {`STEIF_LEN_W{1'b0}};
      end else if (state_reg == ST_CONV && rise[`STEIF_IX_ACLK]) begin
        aclk_cnt_reg <= aclk_cnt_reg + `STEIF_LEN_ONE; // RL5
      end
      // The sampled analog value becomes the result that the next frame shifts out.
      if (state_reg == ST_READY) begin
        held_result_reg <= result_reg;
        conv_done_reg   <= 1'b1;
      end else if (start_conv) begin
        conv_done_reg   <= 1'b0;
      end
    end
  end

  // Register writes: sampled analog value and conversion length.
  always @(posedge ref_clk) begin
    if (rst) begin
      result_reg   <= `STEIF_RESULT_RESET;
      conv_len_reg <= `STEIF_LEN_RESET;
    end else if (reg_wr) begin
      if (reg_addr == `STEIF_OFS_RESULT) begin
        result_reg <= reg_wdata[`STEIF_CONV_W-1:0];
      end else if (reg_addr == `STEIF_OFS_CONV_LEN) begin
        // A zero length would wrap to 256 conversion clock edges, so it is held at one instead.
        if (reg_wdata[`STEIF_LEN_W-1:0] == {`STEIF_LEN_W{1'b0}}) begin
          conv_len_reg <= `STEIF_LEN_ONE;
        end else begin
          conv_len_reg <= reg_wdata[`STEIF_LEN_W-1:0];
        end
      end
    end
  end

  // Register reads answer in the next cycle; unmapped offsets read zero.
  always @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata <= `STEIF_WORD_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= `STEIF_WORD_ZERO;
      if (reg_addr == `STEIF_OFS_STATUS) begin
        reg_rdata[`STEIF_ST_BATT]      <= batt_mode_reg;
        reg_rdata[`STEIF_ST_FLAG_A]    <= transient_flag_a;
        reg_rdata[`STEIF_ST_FLAG_B]    <= transient_flag_b;
        reg_rdata[`STEIF_ST_CONV_BUSY] <= (state_reg == ST_CONV);
        reg_rdata[`STEIF_ST_CONV_DONE] <= conv_done_reg;
        reg_rdata[`STEIF_ST_CNT_MSB:`STEIF_ST_CNT_LSB] <= shock_cnt_reg;
      end else if (reg_addr == `STEIF_OFS_RESULT) begin
        reg_rdata[`STEIF_CONV_W-1:0] <= result_reg;
      end else if (reg_addr == `STEIF_OFS_CONFIG) begin
        reg_rdata[`STEIF_CONV_W-1:0] <= config_reg;
      end else if (reg_addr == `STEIF_OFS_CONV_LEN) begin
        reg_rdata[`STEIF_LEN_W-1:0] <= conv_len_reg;
      end
    end else begin
      reg_rdata <= `STEIF_WORD_ZERO;
    end
  end

endmodule // steif_top

`default_nettype wire

// [shared/steif_regs.vh]
// Register offsets, field positions, reset values and widths of the event interface.
`ifndef STEIF_REGS_VH
`define STEIF_REGS_VH

// Register bus geometry.
`define STEIF_ADDR_W        8
`define STEIF_DATA_W        32

// Register offsets (byte addresses, one aligned word each).
`define STEIF_OFS_STATUS    8'h00
`define STEIF_OFS_RESULT    8'h04
`define STEIF_OFS_CONFIG    8'h08
`define STEIF_OFS_CONV_LEN  8'h0C

// Status register field positions.
`define STEIF_ST_BATT       0
`define STEIF_ST_FLAG_A     1
`define STEIF_ST_FLAG_B     2
`define STEIF_ST_CONV_BUSY  3
`define STEIF_ST_CONV_DONE  4
`define STEIF_ST_CNT_LSB    8
`define STEIF_ST_CNT_MSB    14

// Shock counter geometry.
`define STEIF_CNT_W         7
`define STEIF_CNT_MAX       7'h7F
`define STEIF_CNT_ONE       7'h01
`define STEIF_CNT_ZERO      7'h00

// Converter word geometry.
`define STEIF_CONV_W        12
`define STEIF_BITCNT_W      5
`define STEIF_BITCNT_ZERO   5'h00
`define STEIF_BITCNT_ONE    5'h01
`define STEIF_BITCNT_FULL   5'h0C

// Conversion length in conversion clock edges.
`define STEIF_LEN_W         8
`define STEIF_LEN_RESET     8'h0E
`define STEIF_LEN_ONE       8'h01

// Reset values.
`define STEIF_RESULT_RESET  12'h000
`define STEIF_WORD_ZERO     32'h0000_0000

// Synchroniser inputs: positions in the synchronised vector.
`define STEIF_NSYNC         10
`define STEIF_IX_SEL_N      0
`define STEIF_IX_SDI        1
`define STEIF_IX_SCLK       2
`define STEIF_IX_ACLK       3
`define STEIF_IX_ADV        4
`define STEIF_IX_CLR        5
`define STEIF_IX_TEST       6
`define STEIF_IX_SHOCK      7
`define STEIF_IX_HIT_A      8
`define STEIF_IX_HIT_B      9

`endif

// [verif/steif_ctl_model.sv]
// Controller-side model that drives the converter select, shift clock and conversion clock.
`timescale 1ns/1ps
`default_nettype none

module steif_ctl_model (
  // Answer from the device.
  input  wire logic conv_sdo,
  input  wire logic conv_sdo_oe,
  // Lines driven toward the device.
  output var  logic conv_select_n,
  output var  logic conv_sdi,
  output var  logic conv_sclk,
  output var  logic conv_aclk
);
  // Idle: deselected and both clocks still between frames.
  initial begin
    conv_select_n = 1'b1;
    conv_sdi      = 1'b0;
    conv_sclk     = 1'b0;
    conv_aclk     = 1'b0;
  end

  // One frame, MSB first; the answer bit is taken late in the high phase, clear of the shift.
  task automatic frame(input logic [11:0] cfg, input int nbits, output logic [11:0] got);
    got = 12'h000;
    #7 conv_select_n = 1'b0;
    #40;
    for (int i = 0; i < nbits; i++) begin
      conv_sdi = cfg[11 - i];
      #80 conv_sclk = 1'b1;
      #80 got = {got[10:0], conv_sdo_oe ? conv_sdo : 1'bx};
      conv_sclk = 1'b0;
    end
    #80 conv_select_n = 1'b1;
    // A released data line shows the inverse, so a stale bit never looks valid.
    conv_sdi = ~conv_sdi;
    #160;
  endtask

  // Conversion clock runs only for the asked number of rising edges.
  task automatic convert(input int edges);
    repeat (edges) begin
      #80 conv_aclk = 1'b1;
      #80 conv_aclk = 1'b0;
    end
  endtask
endmodule // steif_ctl_model

`default_nettype wire

// [verif/steif_top_assertions.sv]
// Concurrent checks on the top-level pins of the event interface.
`timescale 1ns/1ps
`default_nettype none

module steif_top_assertions (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic rst,
  // Converter port.
  input wire logic conv_select_n,
  input wire logic conv_sclk,
  input wire logic conv_sdo,
  input wire logic conv_sdo_oe,
  // Shock and transient lines.
  input wire logic shock_advance,
  input wire logic shock_count_msb,
  input wire logic shock_irq,
  input wire logic shock_detect,
  input wire logic batt_above_main,
  input wire logic transient_flag_clear,
  input wire logic transient_self_test,
  input wire logic transient_flag_a,
  input wire logic transient_flag_b,
  input wire logic transient_hit_a,
  input wire logic transient_hit_b
);
  // Pins pass two flops first, so each window leaves room for that latency.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_sticky;
    $fell(transient_flag_a) |-> $past(transient_flag_clear, 2) || $past(transient_flag_clear, 3);
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag a dropped without clear");
  property p_hit;
    (transient_hit_a && !batt_above_main) [*4] |-> transient_flag_a;
  endproperty
  a_hit: assert property (p_hit) else $error("flag a not set by held hit");
  property p_test;
    $rose(transient_self_test) && !batt_above_main ##1 (!batt_above_main) [*5]
      |-> transient_flag_a && transient_flag_b;
  endproperty
  a_test: assert property (p_test) else $error("self test did not set flags");
  property p_clear;
    (transient_flag_clear && !transient_self_test && !transient_hit_a && !transient_hit_b
      && !batt_above_main) [*4] |-> !transient_flag_a && !transient_flag_b;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left a flag set");
  property p_batt;
    batt_above_main [*5] |-> !shock_irq && !shock_count_msb;
  endproperty
  a_batt: assert property (p_batt) else $error("outputs active in battery mode");
  property p_irq;
    (shock_detect && !batt_above_main) [*5] |-> shock_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("shock not reported");
  property p_oe;
    conv_select_n [*6] |-> !conv_sdo_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("output driven while deselected");
  property p_msb;
    (!batt_above_main && !shock_advance) [*6] |-> $stable(shock_count_msb);
  endproperty
  a_msb: assert property (p_msb) else $error("counter moved under main power");
  property p_sdo;
    (conv_sclk && !conv_select_n) [*3] |-> $stable(conv_sdo);
  endproperty
  a_sdo: assert property (p_sdo) else $error("output moved off a shift edge");
endmodule // steif_top_assertions

bind steif_top steif_top_assertions i_chk (.ref_clk(ref_clk), .rst(rst),
  .conv_select_n(conv_select_n), .conv_sclk(conv_sclk), .conv_sdo(conv_sdo),
  .conv_sdo_oe(conv_sdo_oe), .shock_advance(shock_advance), .shock_count_msb(shock_count_msb),
  .shock_irq(shock_irq), .shock_detect(shock_detect), .batt_above_main(batt_above_main),
  .transient_flag_clear(transient_flag_clear), .transient_self_test(transient_self_test),
  .transient_flag_a(transient_flag_a), .transient_flag_b(transient_flag_b),
  .transient_hit_a(transient_hit_a), .transient_hit_b(transient_hit_b));

`default_nettype wire

// [verif/steif_top_test.sv]
// Self-checking bench for the shock, transient and converter link.
`timescale 1ns/1ps
`default_nettype none
`include "steif_regs.vh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end

module steif_top_test;
  logic        ref_clk, rst, reg_wr, reg_rd, sel_n, sdi, sclk, aclk, sdo, sdo_oe;
  logic        adv, msb, s_irq, t_clr, t_test, fl_a, fl_b, t_irq, s_det, hit_a, hit_b, batt;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_val;
  logic [11:0] cfg_word, res_word, got_word;
  logic [6:0]  count_exp;
  int          fails, checks, n;

  // Every device input is driven by the bench or by the controller model.
  steif_top i_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_select_n(sel_n),
    .conv_sdi(sdi), .conv_sclk(sclk), .conv_aclk(aclk), .conv_sdo(sdo), .conv_sdo_oe(sdo_oe),
    .shock_advance(adv), .shock_count_msb(msb), .shock_irq(s_irq), .transient_flag_clear(t_clr),
    .transient_self_test(t_test), .transient_flag_a(fl_a), .transient_flag_b(fl_b),
    .transient_irq(t_irq), .shock_detect(s_det), .transient_hit_a(hit_a),
    .transient_hit_b(hit_b), .batt_above_main(batt));
  steif_ctl_model i_ctl (.conv_sdo(sdo), .conv_sdo_oe(sdo_oe), .conv_select_n(sel_n),
    .conv_sdi(sdi), .conv_sclk(sclk), .conv_aclk(aclk));

  // 50 MHz system clock.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk);
  endtask
  // Bus cycles: one-cycle strobes; read data is taken in the cycle after the strobe.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(negedge ref_clk);
    rd_val = reg_rdata;
  endtask
  // Event lines are held four cycles each way, long enough for the synchronisers.
  task automatic pulse(input logic [5:0] m);
    {s_det, adv, hit_a, hit_b, t_clr, t_test} <= m;
    cyc(4);
    {s_det, adv, hit_a, hit_b, t_clr, t_test} <= 6'b00_0000;
    cyc(4);
  endtask
  function automatic logic [6:0] sat_cnt(input logic [6:0] c, input int k);
    sat_cnt = (int'(c) + k > 127) ? `STEIF_CNT_MAX : 7'(int'(c) + k);
  endfunction
  task automatic print_verdict();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // A hang is cut short well past the few thousand cycles the tests need.
  initial begin
    cyc(50000);
    fails++;
    print_verdict();
  end

  initial begin
    n = $urandom(32'h0b88_88a2);
    {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 42'h0};
    {s_det, adv, hit_a, hit_b, t_clr, t_test, batt} = 7'h00;
    cyc(5);
    rst <= 1'b0;
    rd(`STEIF_OFS_CONV_LEN);
    `CHK(rd_val, 32'h0000_000E)
    wr(`STEIF_OFS_STATUS, 32'hFFFF_FFFF);
    rd(`STEIF_OFS_STATUS);
    `CHK(rd_val, `STEIF_WORD_ZERO)
    rd(8'h10);
    `CHK(rd_val, `STEIF_WORD_ZERO)
    wr(`STEIF_OFS_CONV_LEN, 32'h0000_0000);
    rd(`STEIF_OFS_CONV_LEN);
    `CHK(rd_val, 32'h0000_0001)
    wr(`STEIF_OFS_CONV_LEN, 32'h0000_0003);
    // Flags: each source sets them, they stay set, and clear drops a flag unless its hit is held in the same cycle.
    pulse(6'b00_1000);
    `CHK({fl_a, fl_b, t_irq}, 3'b101)
    cyc($urandom_range(20, 60));
    `CHK({fl_a, fl_b, t_irq}, 3'b101)
    pulse(6'b00_0110);
    `CHK({fl_a, fl_b, t_irq}, 3'b011)
    pulse(6'b00_0010);
    `CHK({fl_a, fl_b, t_irq}, 3'b000)
    pulse(6'b00_0001);
    `CHK({fl_a, fl_b, t_irq}, 3'b111)
    pulse(6'b00_0010);
    // Under main power a shock is reported at once and never counted.
    s_det <= 1'b1;
    cyc(5);
    `CHK(s_irq, 1'b1)
    pulse(6'b00_0000);
    rd(`STEIF_OFS_STATUS);
    `CHK(rd_val[14:8], 7'h00)
    // Battery mode: shocks count and saturate; flags and advance are frozen.
    batt <= 1'b1;
    cyc(5);
    n = $urandom_range(1, 20);
    repeat (n) pulse(6'b10_0000);
    pulse(6'b01_1000);
    rd(`STEIF_OFS_STATUS);
    `CHK(rd_val[14:8], sat_cnt(7'h00, n))
    `CHK({rd_val[0], fl_a, msb, s_irq}, 4'b1000)
    repeat (130) pulse(6'b10_0000);
    rd(`STEIF_OFS_STATUS);
    `CHK(rd_val[14:8], sat_cnt(sat_cnt(7'h00, n), 130))
    batt <= 1'b0;
    cyc(5);
    `CHK(msb, 1'b1)
    pulse(6'b01_0000);
    `CHK(msb, 1'b0)
    n = $urandom_range(60, 80);
    repeat (n) pulse(6'b01_0000);
    count_exp = 7'(n);
    `CHK(msb, count_exp[6])
    rd(`STEIF_OFS_STATUS);
    `CHK(rd_val[14:8], count_exp)
    // Converter: config in, conversion, then the latched result out; a short frame is refused.
    {res_word, cfg_word} = 24'($urandom);
    wr(`STEIF_OFS_RESULT, {20'h0_0000, res_word});
    i_ctl.frame(cfg_word, 12, got_word);
    rd(`STEIF_OFS_STATUS);
    `CHK(rd_val[4:3], 2'b01)
    i_ctl.convert(3);
    cyc(6);
    rd(`STEIF_OFS_STATUS);
    `CHK(rd_val[4:3], 2'b10)
    i_ctl.frame(~cfg_word, 8, got_word);
    `CHK(got_word, {4'h0, res_word[11:4]})
    rd(`STEIF_OFS_CONFIG);
    `CHK(rd_val[11:0], cfg_word)
    i_ctl.frame(cfg_word, 12, got_word);
    `CHK(got_word, res_word)
    print_verdict();
  end
endmodule // steif_top_test

`default_nettype wire
